//--- rtl/stc_link_test_ctrl.sv
// link test generator and checksum control top level
`default_nettype none

module stc_link_test_ctrl #(
  parameter int LANES = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // transmit link power-down, same clock
  input wire logic link_pd,
  // user pattern words 1 to 4
  input wire logic [15:0] user_pattern [4],
  // link configuration bytes and checksum
  input wire logic [7:0] cfg_bytes [13],
  output logic [7:0] cfg_checksum,
  // sample input stage
  input wire logic [15:0] smp_in [LANES],
  output logic [15:0] smp_out [LANES],
  // scrambler input stage
  input wire logic [7:0] oct_in [LANES],
  output logic [7:0] oct_out [LANES],
  // serializer input stage
  input wire logic [9:0] sym_in [LANES],
  output logic [9:0] sym_out [LANES],
  // status
  output logic test_active
);
  logic [7:0] ctrl;
  logic [7:0] byte_sum;
  logic [7:0] field_sum;
  logic [7:0] next_checksum;
  logic [7:0] next_rdata;
  wire logic csum_dis;
  wire logic csum_mode;
  wire logic [1:0] inj;
  wire logic [3:0] mode;
  wire logic run;
  wire logic hit;
  wire logic to_smp;
  wire logic to_oct;
  wire logic to_sym;
  stc_gen_if gif ();

  // elaboration guard
  if (LANES < 1) begin : g_bad_lanes
    $error("LANES must be at least one");
  end

  // -----------------------------------------------------------------
  // control register
  // -----------------------------------------------------------------
  assign hit = reg_addr == stc_pkg::ADDR_CTRL;
  assign next_rdata = hit ? ctrl : 8'h00; // unmapped addresses read zero
  assign csum_dis = ctrl[stc_pkg::CSUM_DIS_BIT];
  assign csum_mode = ctrl[stc_pkg::CSUM_MODE_BIT];
  assign inj = ctrl[stc_pkg::INJ_LSB +: 2];
  assign mode = ctrl[stc_pkg::MODE_LSB +: 4];

  // write and registered read-back
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl <= stc_pkg::CTRL_RESET;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && hit) begin
        ctrl <= reg_wdata;
      end
      reg_rdata <= next_rdata;
    end
  end

  // -----------------------------------------------------------------
  // checksum; configuration is only changed while powered down, so a
  // one-cycle lag here is never seen on the link
  // -----------------------------------------------------------------
  function automatic logic [7:0] sum_bytes(input logic [7:0] b [13]);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < stc_pkg::CFG_BYTES; i++) begin
      s = s + b[i];
    end
    return s;
  endfunction

  function automatic logic [7:0] sum_fields(input logic [7:0] b [13]);
    logic [7:0] s;
    logic [10:0] f;
    logic [7:0] msk;
    s = 8'h00;
    for (int i = 0; i < stc_pkg::NUM_FIELDS; i++) begin
      f = stc_pkg::FIELD_TAB[i];
      msk = 8'((9'h001 << f[3:0]) - 9'h001);
      s = s + ((b[f[10:7]] >> f[6:4]) & msk);
    end
    return s;
  endfunction

  assign byte_sum = sum_bytes(cfg_bytes);
  assign field_sum = sum_fields(cfg_bytes);
  assign next_checksum = csum_dis ? 8'h00 : (csum_mode ? field_sum : byte_sum);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_checksum <= 8'h00;
    end else begin
      cfg_checksum <= next_checksum;
    end
  end

  // -----------------------------------------------------------------
  // generator hookup; power-down holds it at its start point
  // -----------------------------------------------------------------
  assign run = (mode != stc_pkg::MODE_OFF) && !link_pd;
  assign gif.mode = mode;
  assign gif.run = run;
  assign gif.upat = user_pattern;
  assign to_smp = run && inj == stc_pkg::INJ_SAMPLE;
  assign to_sym = run && inj == stc_pkg::INJ_SYMBOL;
  assign to_oct = run && inj == stc_pkg::INJ_OCTET;
  assign test_active = run;

  stc_pattern_gen u_gen (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .g(gif.gen)
  );

  // -----------------------------------------------------------------
  // per-lane injection; select 11 passes data untouched
  // -----------------------------------------------------------------
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        smp_out[l] <= 16'h0000;
        oct_out[l] <= 8'h00;
        sym_out[l] <= 10'h000;
      end else begin
        smp_out[l] <= to_smp ? gif.word : smp_in[l];
        oct_out[l] <= to_oct ? gif.word[15:8] : oct_in[l];
        sym_out[l] <= to_sym ? gif.word[15:6] : sym_in[l];
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  // sampled reset keeps the release edge out: its consequent still sees reset values
  AST_CSUM_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !sys_rst && csum_dis |=> cfg_checksum == 8'h00)
    else $error("checksum not zero while disabled");
  AST_CSUM_BYTES: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !sys_rst && !csum_dis && !csum_mode |=> cfg_checksum == $past(byte_sum))
    else $error("byte checksum wrong");
  AST_CSUM_FIELDS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !sys_rst && !csum_dis && csum_mode |=> cfg_checksum == $past(field_sum))
    else $error("field checksum wrong");
  AST_INJ_SAMPLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    to_smp |=> smp_out[0] == $past(gif.word) && oct_out[0] == $past(oct_in[0]))
    else $error("sample injection wrong");
  AST_INJ_SYMBOL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    to_sym |=> sym_out[0] == $past(gif.word[15:6]) && smp_out[0] == $past(smp_in[0]))
    else $error("symbol injection wrong");
  AST_INJ_OCTET: assert property (@(posedge sys_clk) disable iff (sys_rst)
    to_oct |=> oct_out[0] == $past(gif.word[15:8]) && sym_out[0] == $past(sym_in[0]))
    else $error("octet injection wrong");
  AST_NORMAL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !sys_rst && mode == stc_pkg::MODE_OFF |=>
      smp_out[0] == $past(smp_in[0]) && !$past(test_active))
    else $error("normal mode altered data");
  AST_ALL_LANES: assert property (@(posedge sys_clk) disable iff (sys_rst)
    to_smp |=> smp_out[LANES-1] == $past(gif.word))
    else $error("last lane misses the sample pattern");
  AST_PD_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    link_pd |=> gif.word == 16'h0000)
    else $error("generator not held at its start during power-down");

  // register port steps: a write, then a read of the same register
  sequence s_ctrl_write;
    reg_wr && hit;
  endsequence

  sequence s_ctrl_read;
    hit;
  endsequence

  AST_READBACK: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_ctrl_write ##1 s_ctrl_read |=> reg_rdata == $past(reg_wdata, 2))
    else $error("control register read-back wrong");
  AST_RDATA_UNMAPPED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !sys_rst && !hit |=> reg_rdata == 8'h00)
    else $error("unmapped address does not read zero");

  // -----------------------------------------------------------------
  // lane and generator checks; lane 0 alone would hide a per-lane slip
  // -----------------------------------------------------------------
  AST_OCT_LANES: assert property (@(posedge sys_clk) disable iff (sys_rst)
    to_oct |=> oct_out[LANES-1] == $past(gif.word[15:8]))
    else $error("last lane misses the octet pattern");
  AST_SYM_LANES: assert property (@(posedge sys_clk) disable iff (sys_rst)
    to_sym |=> sym_out[LANES-1] == $past(gif.word[15:6]))
    else $error("last lane misses the symbol pattern");
  AST_INJ_RESERVED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    run && inj == 2'h3 |=> smp_out[0] == $past(smp_in[0]) && oct_out[0] == $past(oct_in[0])
      && sym_out[0] == $past(sym_in[0]))
    else $error("reserved select altered data");
  AST_TOGGLE_ALT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (run && mode == stc_pkg::MODE_TOGGLE)[*3] |-> gif.word == ~$past(gif.word))
    else $error("word toggle does not alternate");
  AST_RAMP_STEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (run && mode == stc_pkg::MODE_RAMP)[*3] |-> gif.word == $past(gif.word) + 16'h0001)
    else $error("ramp does not step by one");
  AST_PN_SHIFT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (run && mode == stc_pkg::MODE_PN)[*3] |-> gif.word[15:1] == $past(gif.word[14:0]))
    else $error("pn word does not shift by one");
endmodule

`default_nettype wire

//--- rtl/stc_pkg.sv
// constants shared by the link test and checksum control block
//
// Functional notes
// - checksum-disable bit set sends zero checksum; clear sends computed checksum
// - checksum-mode clear: checksum is the sum of all link configuration bytes
// - checksum-mode set: checksum sums each configuration field, LSB aligned
// - injection select 00 puts 16-bit generator words at sample input
// - injection select 01 puts 10-bit generator symbols at serializer input
// - injection select 10 puts generator octets at scrambler input; 11 reserved
// - mode 0 normal; 1 checkerboard, 2 word toggle, 3 long PN, 7 ramp
// - mode 5 repeats user pattern words 1 to 4, one per cycle
// - mode 6 sends user words 1 to 4 once, then all zeros
// - modes 8, 10, 11 send modified RPAT, JSPAT, JTSPAT 10-bit sequences
`default_nettype none

package stc_pkg;
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam int REG_ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h061;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CSUM_DIS_BIT = 7;
  localparam int CSUM_MODE_BIT = 6;
  localparam int INJ_LSB = 4;
  localparam int MODE_LSB = 0;

  // -----------------------------------------------------------------
  // encodings
  // -----------------------------------------------------------------
  localparam logic [1:0] INJ_SAMPLE = 2'h0;
  localparam logic [1:0] INJ_SYMBOL = 2'h1;
  localparam logic [1:0] INJ_OCTET = 2'h2;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CHECKER = 4'h1;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_PN = 4'h3;
  localparam logic [3:0] MODE_USER_REP = 4'h5;
  localparam logic [3:0] MODE_USER_ONE = 4'h6;
  localparam logic [3:0] MODE_RAMP = 4'h7;
  localparam logic [3:0] MODE_RPAT = 4'h8;
  localparam logic [3:0] MODE_JSPAT = 4'ha;
  localparam logic [3:0] MODE_JTSPAT = 4'hb;

  // -----------------------------------------------------------------
  // generator constants
  // -----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int USER_WORDS = 4;
  localparam logic [15:0] CHECKER_A = 16'haaaa;
  localparam logic [15:0] CHECKER_B = 16'h5555;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  localparam logic [22:0] PN_SEED = 23'h7fffff;
  localparam int SEQ_LEN = 4;
  localparam logic [9:0] RPAT_TAB [SEQ_LEN] = '{10'h0be, 10'h0c5, 10'h2f4, 10'h30b};
  localparam logic [9:0] JSPAT_TAB [SEQ_LEN] = '{10'h17c, 10'h283, 10'h0f3, 10'h30c};
  localparam logic [9:0] JTSPAT_TAB [SEQ_LEN] = '{10'h1e6, 10'h219, 10'h0d5, 10'h32a};

  // -----------------------------------------------------------------
  // link configuration layout: {byte, lsb, width} per field
  // -----------------------------------------------------------------
  localparam int CFG_BYTES = 13;
  localparam int NUM_FIELDS = 21;
  localparam logic [10:0] FIELD_TAB [NUM_FIELDS] = '{
    {4'd0, 3'd0, 4'd8}, {4'd1, 3'd0, 4'd4}, {4'd1, 3'd4, 4'd4}, {4'd2, 3'd0, 4'd5},
    {4'd2, 3'd5, 4'd1}, {4'd2, 3'd6, 4'd1}, {4'd3, 3'd0, 4'd5}, {4'd3, 3'd7, 4'd1},
    {4'd4, 3'd0, 4'd8}, {4'd5, 3'd0, 4'd5}, {4'd6, 3'd0, 4'd8}, {4'd7, 3'd0, 4'd5},
    {4'd7, 3'd6, 4'd2}, {4'd8, 3'd0, 4'd5}, {4'd8, 3'd5, 4'd3}, {4'd9, 3'd0, 4'd5},
    {4'd9, 3'd5, 4'd3}, {4'd10, 3'd0, 4'd5}, {4'd10, 3'd7, 4'd1}, {4'd11, 3'd0, 4'd8},
    {4'd12, 3'd0, 4'd8}};
endpackage

`default_nettype wire

//--- rtl/stc_gen_if.sv
// carrier between the control top and the pattern generator
`default_nettype none

interface stc_gen_if;
  logic [3:0] mode;
  logic run;
  logic [15:0] upat [4];
  logic [15:0] word;
  modport ctrl (output mode, output run, output upat, input word);
  modport gen (input mode, input run, input upat, output word);
endinterface

`default_nettype wire

//--- rtl/stc_pattern_gen.sv
// test pattern generator: one 16-bit word per clock, MSB aligned
`default_nettype none

module stc_pattern_gen (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control and pattern
  stc_gen_if.gen g
);
  logic phase;
  logic [22:0] lfsr;
  logic [15:0] ramp;
  logic [2:0] uidx;
  logic [1:0] sidx;
  logic [15:0] next_word;

  // -----------------------------------------------------------------
  // pattern select
  // -----------------------------------------------------------------
  function automatic logic [15:0] pat_sel(input logic [3:0] m);
    logic [15:0] w;
    w = 16'h0000;
    unique case (m)
      stc_pkg::MODE_CHECKER: w = phase ? stc_pkg::CHECKER_B : stc_pkg::CHECKER_A;
      stc_pkg::MODE_TOGGLE: w = phase ? 16'h0000 : stc_pkg::ALL_ONES;
      stc_pkg::MODE_PN: w = lfsr[22:7];
      stc_pkg::MODE_RAMP: w = ramp;
      stc_pkg::MODE_USER_REP: w = g.upat[uidx[1:0]];
      stc_pkg::MODE_USER_ONE: w = uidx[2] ? 16'h0000 : g.upat[uidx[1:0]];
      stc_pkg::MODE_RPAT: w = {stc_pkg::RPAT_TAB[sidx], 6'h00};
      stc_pkg::MODE_JSPAT: w = {stc_pkg::JSPAT_TAB[sidx], 6'h00};
      stc_pkg::MODE_JTSPAT: w = {stc_pkg::JTSPAT_TAB[sidx], 6'h00};
      default: w = 16'h0000; // off and unused codes give zeros
    endcase
    return w;
  endfunction

  // a process, not an assign: the function reads state that is not an argument
  always_comb begin
    next_word = pat_sel(g.mode);
  end

  // -----------------------------------------------------------------
  // sequence state, restarted whenever the generator is idle
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !g.run) begin
      phase <= 1'b0;
      lfsr <= stc_pkg::PN_SEED;
      ramp <= 16'h0000;
      uidx <= 3'h0;
      sidx <= 2'h0;
      g.word <= 16'h0000;
    end else begin
      phase <= ~phase;
      lfsr <= {lfsr[21:0], lfsr[22] ^ lfsr[17]};
      ramp <= ramp + 16'h0001;
      // repeat mode wraps after word 4, single mode parks past it
      if (g.mode == stc_pkg::MODE_USER_REP) begin
        uidx <= {1'b0, uidx[1:0] + 2'h1};
      end else if (!uidx[2]) begin
        uidx <= uidx + 3'h1;
      end
      sidx <= sidx + 2'h1;
      g.word <= next_word;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_single_start;
    $rose(g.run) && g.mode == stc_pkg::MODE_USER_ONE;
  endsequence

  AST_SINGLE_FIRST: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_single_start |=> g.word == g.upat[0])
    else $error("single user mode first word wrong");
  AST_SINGLE_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_single_start ##1 (g.run && g.mode == stc_pkg::MODE_USER_ONE)[*5] |-> g.word == 16'h0000)
    else $error("single user mode not zero after four words");
  AST_REPEAT_FOUR: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (g.run && g.mode == stc_pkg::MODE_USER_REP)[*6] |-> g.word == $past(g.word, 4))
    else $error("repeat user mode period not four");
  AST_CHECKER_ALT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (g.run && g.mode == stc_pkg::MODE_CHECKER)[*3] |-> g.word == ~$past(g.word))
    else $error("checkerboard does not alternate");
endmodule

`default_nettype wire

//--- testbench/stc_link_rx_model.sv
// far end receiver model: captures serializer symbols and checks lane agreement
`default_nettype none

module stc_link_rx_model #(
  parameter int LANES = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // serializer symbols of all lanes
  input wire logic [9:0] sym_rx [LANES],
  // status
  output logic lanes_same
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cap [LANES];

  // a test pattern must reach every lane alike
  always_comb begin
    lanes_same = 1'b1;
    for (int i = 1; i < LANES; i++) begin
      if (cap[i] !== cap[0]) lanes_same = 1'b0;
    end
  end

  // capture one symbol set per clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cap <= '{default: 10'h000};
    end else begin
      cap <= sym_rx;
    end
  end
endmodule

`default_nettype wire

//--- testbench/serial_link_test_checksum_ctrl_tb_top.sv
// bench top: random traffic against a behavioural model of the control block
`default_nettype none

module serial_link_test_checksum_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LN = 4;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] reg_addr = 12'h061;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic link_pd = 1'b1;
  logic [15:0] user_pattern [4] = '{default: 16'h0000};
  logic [7:0] cfg_bytes [13] = '{default: 8'h00};
  logic [7:0] cfg_checksum;
  logic [15:0] smp_in [LN] = '{default: 16'h0000};
  logic [15:0] smp_out [LN];
  logic [7:0] oct_in [LN] = '{default: 8'h00};
  logic [7:0] oct_out [LN];
  logic [9:0] sym_in [LN] = '{default: 10'h000};
  logic [9:0] sym_out [LN];
  logic test_active;
  logic lanes_same;
  // model state
  logic [7:0] ctrl_m = 8'h00;
  logic [15:0] word_m = 16'h0000;
  logic [15:0] e_smp [LN];
  logic [7:0] e_oct [LN];
  logic [9:0] e_sym [LN];
  logic [7:0] e_csum;
  logic [7:0] e_rd;
  logic run;
  logic [22:0] pn_m = stc_pkg::PN_SEED;
  logic started = 1'b0;
  logic [10:0] f;
  int n = 0;
  int bsum;
  int fsum;
  int num_errors = 0;
  int cmp_count = 0;
  logic [3:0] modes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hb};

  stc_link_test_ctrl #(.LANES(LN)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .link_pd(link_pd), .user_pattern(user_pattern), .cfg_bytes(cfg_bytes),
    .cfg_checksum(cfg_checksum), .smp_in(smp_in), .smp_out(smp_out), .oct_in(oct_in),
    .oct_out(oct_out), .sym_in(sym_in), .sym_out(sym_out), .test_active(test_active));
  stc_link_rx_model #(.LANES(LN)) rx (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .sym_rx(sym_out), .lanes_same(lanes_same));

  always #4 sys_clk = ~sys_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // generator word k of a run; pn words come from the model register
  function automatic logic [15:0] pat(input logic [3:0] md, input int k);
    case (md)
      4'h1: pat = k[0] ? 16'h5555 : 16'haaaa;
      4'h2: pat = k[0] ? 16'h0000 : 16'hffff;
      4'h3: pat = pn_m[22:7];
      4'h5: pat = user_pattern[k % 4];
      4'h6: pat = (k < 4) ? user_pattern[k] : 16'h0000;
      4'h7: pat = k[15:0];
      4'h8: pat = {stc_pkg::RPAT_TAB[k % 4], 6'h00};
      4'ha: pat = {stc_pkg::JSPAT_TAB[k % 4], 6'h00};
      4'hb: pat = {stc_pkg::JTSPAT_TAB[k % 4], 6'h00};
      default: pat = 16'h0000;
    endcase
  endfunction

  // random lane streams, new every clock
  always @(posedge sys_clk) begin
    for (int i = 0; i < LN; i++) begin
      smp_in[i] <= $urandom;
      oct_in[i] <= $urandom;
      sym_in[i] <= $urandom;
    end
  end

  // compare last prediction, then predict the next edge from settled inputs
  always @(negedge sys_clk) begin
    run = ctrl_m[3:0] != 4'h0 && !link_pd;
    if (started) begin
      for (int i = 0; i < LN; i++) begin
        chk(smp_out[i], e_smp[i]);
        chk(oct_out[i], e_oct[i]);
        chk(sym_out[i], e_sym[i]);
      end
      chk(cfg_checksum, e_csum);
      chk(reg_rdata, e_rd);
      chk(test_active, run);
    end
    started = 1'b1;
    for (int i = 0; i < LN; i++) begin
      e_smp[i] = (run && ctrl_m[5:4] == 2'h0) ? word_m : smp_in[i];
      e_sym[i] = (run && ctrl_m[5:4] == 2'h1) ? word_m[15:6] : sym_in[i];
      e_oct[i] = (run && ctrl_m[5:4] == 2'h2) ? word_m[15:8] : oct_in[i];
    end
    bsum = 0;
    fsum = 0;
    for (int k = 0; k < 13; k++) bsum += cfg_bytes[k];
    for (int k = 0; k < stc_pkg::NUM_FIELDS; k++) begin
      f = stc_pkg::FIELD_TAB[k];
      fsum += (int'(cfg_bytes[f[10:7]]) >> f[6:4]) & ((1 << f[3:0]) - 1);
    end
    e_csum = ctrl_m[7] ? 8'h00 : (ctrl_m[6] ? fsum[7:0] : bsum[7:0]);
    e_rd = (reg_addr == 12'h061) ? ctrl_m : 8'h00;
    word_m = run ? pat(ctrl_m[3:0], n) : 16'h0000;
    // pn23 register, x^23 + x^18 + 1, one shift per running clock
    pn_m = run ? {pn_m[21:0], pn_m[22] ^ pn_m[17]} : stc_pkg::PN_SEED;
    n = run ? n + 1 : 0;
    if (reg_wr && reg_addr == 12'h061) ctrl_m = reg_wdata;
    if (sys_rst) begin
      e_smp = '{default: 16'h0000};
      e_oct = '{default: 8'h00};
      e_sym = '{default: 10'h000};
      e_csum = 8'h00;
      e_rd = 8'h00;
      ctrl_m = 8'h00;
      word_m = 16'h0000;
      pn_m = stc_pkg::PN_SEED;
      n = 0;
    end
  end

  // configure under power-down, then let the link run
  task automatic run_test(input logic [7:0] c);
    @(posedge sys_clk);
    link_pd <= 1'b1;
    reg_addr <= 12'h062;
    reg_wdata <= ~c;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    // pattern words and configuration bytes only change once powered down
    for (int k = 0; k < 4; k++) user_pattern[k] <= $urandom;
    for (int k = 0; k < 13; k++) cfg_bytes[k] <= $urandom;
    reg_addr <= 12'h061;
    reg_wdata <= c;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
    link_pd <= 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 chk(lanes_same, c[5:4] == 2'h1 && c[3:0] != 4'h0);
  endtask

  // watchdog: the tests need well under 2000 clocks
  initial begin
    #40000;
    num_errors++;
    close_out();
  end

  // unused mode codes are never programmed
  initial begin
    void'($urandom(45849));
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int m = 0; m < 10; m++) begin
      for (int s = 0; s < 4; s++) run_test({2'($urandom), 2'(s), modes[m]});
    end
    run_test(8'h05);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    run_test(8'h46);
    close_out();
  end
endmodule

`default_nettype wire
